// *** arx_defs.svh ***
/*
  constants for the read-path endpoint pair: response codes, burst types,
  recommended attributes, reset timing and widths.
  assumes inclusion by bare name from the modules and the testbench.
*/
`ifndef ARX_DEFS_SVH
`define ARX_DEFS_SVH
`define ARX_RESP_OKAY      2'h0
`define ARX_RESP_EXOKAY    2'h1
`define ARX_RESP_SLVERR    2'h2
`define ARX_RESP_DECERR    2'h3
`define ARX_BURST_FIXED    2'h0
`define ARX_BURST_INCR     2'h1
`define ARX_BURST_WRAP     2'h2
`define ARX_CACHE_REC      4'h3
`define ARX_PROT_REC       3'h0
`define ARX_ADDR_W_MIN     32
`define ARX_DATA_W_MIN     32
`define ARX_DATA_W_MAX     1024
`define ARX_SIZE_MAX       3'h7
`define ARX_RST_DROP_CYC   8
`define ARX_RST_MIN_CYC    16
`define ARX_FIFO_DEPTH     8
`define ARX_NATIVE_AW      12
`endif

// *** arx_fifo.sv ***
/*
  small synchronous fifo with valid/ready on both sides.
  assumes a power-of-two depth and one clock.
*/
`timescale 1ns/1ps
module arx_fifo
  import arx_pkg::*;
#(
  parameter int W = 32,
  parameter int D = 8
)(
  input  wire logic         ref_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] in_data_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  output logic [W-1:0]      out_data_out,
  output logic              out_valid_out,
  input  wire logic         out_ready_in
);
  localparam int PW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [PW:0]  wp_r;
  logic [PW:0]  rp_r;
  logic         push;
  logic         pop;

  // full when pointers differ only in the wrap bit
  assign in_ready_out  = !((wp_r[PW] != rp_r[PW]) && (wp_r[PW-1:0] == rp_r[PW-1:0]));
  assign out_valid_out = (wp_r != rp_r);
  assign out_data_out  = mem_r[rp_r[PW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // storage has no reset, only pointers need one
  always_ff @(posedge ref_clk_in)
    if (push)
      mem_r[wp_r[PW-1:0]] <= in_data_in;

  // pointers
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
    end
endmodule

// *** arx_if.sv ***
/*
  read address, read data and write response channels between a master
  and an endpoint slave; parameters set the address, data, id and user widths.
  assumes one clock and active-low reset held by the joining testbench.
*/
`timescale 1ns/1ps
interface arx_if #(
  parameter int AW = 32,
  parameter int DW = 32,
  parameter int IW = 4,
  parameter int UW = 1
);
  // read address channel
  logic [IW-1:0]  arid;
  logic [AW-1:0]  araddr;
  logic [7:0]     arlen;
  logic [2:0]     arsize;
  logic [1:0]     arburst;
  logic           arlock;
  logic [3:0]     arcache;
  logic [2:0]     arprot;
  logic [3:0]     arqos;
  logic [3:0]     arregion;
  logic [UW-1:0]  aruser;
  logic           arvalid;
  logic           arready;
  // read data channel
  logic [IW-1:0]  rid;
  logic [DW-1:0]  rdata;
  logic [1:0]     rresp;
  logic           rlast;
  logic [UW-1:0]  ruser;
  logic           rvalid;
  logic           rready;
  // write response channel
  logic [IW-1:0]  bid;
  logic [1:0]     bresp;
  logic [UW-1:0]  buser;
  logic           bvalid;
  logic           bready;

  modport mst (
    output arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot, arqos,
           arregion, aruser, arvalid, rready, bready,
    input  arready, rid, rdata, rresp, rlast, ruser, rvalid, bid, bresp, buser, bvalid
  );
  modport slv (
    input  arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot, arqos,
           arregion, aruser, arvalid, rready, bready,
    output arready, rid, rdata, rresp, rlast, ruser, rvalid, bid, bresp, buser, bvalid
  );
endinterface

// *** arx_link_chk.sv ***
/*
  assertions on the read and write response channels joining the two ends.
  assumes instantiation beside the interface, one clock, one read at a time.
*/
`timescale 1ns/1ps
`include "arx_defs.svh"
module arx_link_chk #(
  parameter int AW = 32,
  parameter int DW = 32,
  parameter int IW = 4,
  parameter int UW = 1
)(
  input  wire logic          ref_clk_in,
  input  wire logic          rst_n_in,
  input  wire logic [IW-1:0] arid,
  input  wire logic [AW-1:0] araddr,
  input  wire logic [7:0]    arlen,
  input  wire logic [2:0]    arsize,
  input  wire logic [3:0]    arcache,
  input  wire logic [2:0]    arprot,
  input  wire logic          arvalid,
  input  wire logic          arready,
  input  wire logic [IW-1:0] rid,
  input  wire logic [DW-1:0] rdata,
  input  wire logic [1:0]    rresp,
  input  wire logic          rlast,
  input  wire logic [UW-1:0] ruser,
  input  wire logic          rvalid,
  input  wire logic          rready,
  input  wire logic [UW-1:0] buser,
  input  wire logic          bvalid
);
  localparam int WW = $clog2(DW/8);
  logic [7:0]    len_r;
  logic [7:0]    cnt_r;
  logic [3:0]    idx_r;
  logic [IW-1:0] id_r;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // burst shape captured at the address handshake
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      len_r <= 8'h00;
      idx_r <= 4'h0;
      id_r  <= '0;
    end
    else if (arvalid && arready)
    begin
      len_r <= arlen;
      idx_r <= araddr[WW+:4];
      id_r  <= arid;
    end
  end
  // beats seen so far; cleared on the last one so bursts stay separate
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cnt_r <= 8'h00;
    else if (rvalid && rready)
      cnt_r <= rlast ? 8'h00 : cnt_r + 8'h01;
  end
  sequence ar_hs_s;
    arvalid && arready;
  endsequence
  sequence first_beat_s;
    ##3 (rvalid && rdata == DW'(idx_r));
  endsequence
  chk_reset_drops_valids: assert property (disable iff (1'b0) !rst_n_in |-> !rvalid && !arvalid && !bvalid)
    else $error("valid seen during reset");
  chk_ar_stall_busy: assert property (ar_hs_s |=> !arready ##1 (len_r == 8'h00 || !arready))
    else $error("address accepted while a burst runs");
  chk_first_beat_data: assert property (ar_hs_s |-> first_beat_s)
    else $error("first beat late or wrong word");
  chk_last_on_final: assert property (rvalid && rready |-> rlast == (cnt_r == len_r))
    else $error("last flag not on final beat");
  chk_resp_always_okay: assert property (rvalid |-> rresp == `ARX_RESP_OKAY)
    else $error("read response not okay");
  chk_user_bits_zero: assert property (rvalid || bvalid |-> ruser == '0 && buser == '0)
    else $error("user sideband not zero");
  chk_rid_follows_arid: assert property (rvalid |-> rid == id_r)
    else $error("read id differs from address id");
  chk_ar_attrs_rec: assert property (arvalid |-> arsize == 3'(WW) && arcache == `ARX_CACHE_REC
    && arprot == `ARX_PROT_REC)
    else $error("read attributes not as recommended");
endmodule

// *** arx_master.sv ***
/*
  master end: issues one read burst per request and accepts write responses.
  assumes the slave keeps its own rules; one clock, active-low async reset.
*/
`timescale 1ns/1ps
`include "arx_defs.svh"
module arx_master
  import arx_pkg::*;
#(
  parameter int AW = 32,
  parameter int DW = 32,
  parameter int IW = 4,
  parameter int UW = 1
)(
  input  wire logic          ref_clk_in,
  input  wire logic          rst_n_in,
  arx_if.mst                 bus,
  input  wire logic          req_in,
  input  wire logic [AW-1:0] req_addr_in,
  input  wire logic [7:0]    req_len_in,
  input  wire logic [1:0]    req_burst_in,
  input  wire logic [IW-1:0] req_id_in,
  output logic               req_busy_out,
  output logic               beat_valid_out,
  output logic [DW-1:0]      beat_data_out,
  output logic [1:0]         beat_resp_out,
  output logic               beat_last_out,
  output logic               bresp_valid_out,
  output logic [1:0]         bresp_out
);
  localparam logic [2:0] FULL_SIZE = 3'($clog2(DW / 8));
  logic           arvalid_r;
  logic [AW-1:0]  araddr_r;
  logic [7:0]     arlen_r;
  logic [1:0]     arburst_r;
  logic [IW-1:0]  arid_r;

  // address request held until accepted; full-width beats only, recommended attributes
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      arvalid_r <= 1'b0;
      araddr_r  <= '0;
      arlen_r   <= 8'h00;
      arburst_r <= `ARX_BURST_INCR;
      arid_r    <= '0;
    end
    else if (arvalid_r && bus.arready)
      arvalid_r <= 1'b0;
    else if (req_in && !arvalid_r)
    begin
      arvalid_r <= 1'b1;
      araddr_r  <= req_addr_in;
      arlen_r   <= req_len_in;
      arburst_r <= req_burst_in;
      arid_r    <= req_id_in;
    end

  // user-side beat and response capture
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      req_busy_out    <= 1'b0;
      beat_valid_out  <= 1'b0;
      beat_data_out   <= '0;
      beat_resp_out   <= 2'h0;
      beat_last_out   <= 1'b0;
      bresp_valid_out <= 1'b0;
      bresp_out       <= 2'h0;
    end
    else
    begin
      req_busy_out    <= arvalid_r || req_in;
      beat_valid_out  <= bus.rvalid;
      beat_data_out   <= bus.rdata;
      beat_resp_out   <= bus.rresp;
      beat_last_out   <= bus.rvalid && bus.rlast;
      bresp_valid_out <= bus.bvalid;
      bresp_out       <= bus.bresp;
    end

  assign bus.arvalid  = arvalid_r;
  assign bus.araddr   = araddr_r;
  assign bus.arlen    = arlen_r;
  assign bus.arsize   = FULL_SIZE;
  assign bus.arburst  = arburst_r;
  assign bus.arid     = arid_r;
  assign bus.arlock   = 1'b0;
  assign bus.arcache  = `ARX_CACHE_REC;
  assign bus.arprot   = `ARX_PROT_REC;
  assign bus.arqos    = 4'h0;
  assign bus.arregion = 4'h0;
  assign bus.aruser   = '0;
  assign bus.rready   = 1'b1;
  assign bus.bready   = 1'b1;
endmodule

// *** arx_pkg.sv ***
/*
  types shared by both ends of the read path.
  assumes arx_defs.svh is on the include path.
*/
package arx_pkg;
  typedef logic [1:0] arx_resp_t;
  typedef logic [1:0] arx_burst_t;
  typedef enum logic [1:0] {
    ARX_IDLE  = 2'h0,
    ARX_BURST = 2'h1,
    ARX_HOLD  = 2'h3
  } arx_state_e;
endpackage

// *** arx_slave.sv ***
/*
  endpoint slave for the read path and write response channel.
  a small memory answers read bursts through an 8-word fifo; a write
  completion pulse from the user side becomes a write response.
  assumes the master keeps its own rules and the interface is reset by
  rst_n_in for at least 16 clocks.

  // Functional notes
  // - write response id follows read id conventions
  // - lite mode never answers exclusive okay
  // - read-only build removes write response channel
  // - write-only build removes read address channel
  // - master drives only varying id bits
  // - interconnect appends constant master id part
  // - address bus at least 32 bits
  // - slave ignores address bits above range
  // - transfer size covers 8 to 1024 bits
  // - masters avoid narrow read bursts
  // - incrementing and wrapping bursts fully supported
  // - fixed bursts handshake, treated as incrementing
  // - no exclusive access; lock ignored
  // - cache attribute ignored by slave
  // - protection attribute ignored by slave
  // - quality of service ignored
  // - region optional on slave, unused here
  // - user sideband not implemented, driven zero
  // - full data width 32 to 1024
  // - lite data width fixed at 32
  // - valids drop within 8 cycles of reset
*/
`timescale 1ns/1ps
`include "arx_defs.svh"
module arx_slave
  import arx_pkg::*;
#(
  parameter int AW        = 32,
  parameter int DW        = 32,
  parameter int IW        = 4,
  parameter int UW        = 1,
  parameter int NAW       = `ARX_NATIVE_AW,
  parameter bit LITE      = 1'b0,
  parameter bit HAS_READ  = 1'b1,
  parameter bit HAS_WRITE = 1'b1
)(
  input  wire logic          ref_clk_in,
  input  wire logic          rst_n_in,
  arx_if.slv                 bus,
  input  wire logic          wr_done_in,
  input  wire logic [IW-1:0] wr_id_in,
  input  wire logic [1:0]    wr_resp_in,
  output logic               wr_busy_out,
  output logic               rd_busy_out
);
  localparam int WW = (DW / 8 > 1) ? $clog2(DW / 8) : 1;
  localparam int MD = 16;
  localparam int FW = DW + IW + 3;

  // elaboration-time width limits; a bad build stops here instead of misbehaving
  if (AW < `ARX_ADDR_W_MIN)
  begin : g_aw_min
    $error("address narrower than 32");
  end
  if (DW < `ARX_DATA_W_MIN || DW > `ARX_DATA_W_MAX)
  begin : g_dw_range
    $error("data width out of range");
  end
  if (LITE && DW != `ARX_DATA_W_MIN)
  begin : g_lite_dw
    $error("lite data must be 32");
  end

  arx_state_e    st_r;
  logic [NAW-1:0] addr_r;      // upper address bits dropped, so aliases repeat
  logic [7:0]     left_r;
  logic [NAW-1:0] wmask_r;     // full native width so wide beats still wrap
  logic [2:0]     size_r;      // beat size held for the burst, the bus value is gone
  logic           arready_r;
  logic [IW-1:0]  id_r;
  logic [DW-1:0]  mem [MD];
  logic [FW-1:0]  f_in;
  logic [FW-1:0]  f_out;
  logic           f_ready;
  logic           f_valid;
  logic           beat;
  logic           last_beat;
  logic [NAW-1:0] step;
  logic [NAW-1:0] addr_nxt;
  logic [1:0]     rresp_v;
  logic           rvalid_r;
  logic [FW-1:0]  rhold_r;
  logic           bvalid_r;
  logic [IW-1:0]  bid_r;
  logic [1:0]     bresp_r;

  // memory contents: each word holds its own index, enough to tell aliases apart
  always_comb
    for (int i = 0; i < MD; i++)
      mem[i] = DW'(i);

  // address step and wrap; fixed bursts step like incrementing ones
  assign step = NAW'(1) << size_r;
  always_comb
  begin
    addr_nxt = addr_r + step;
    if (st_r == ARX_HOLD)
      addr_nxt = (addr_r & ~wmask_r) | ((addr_r + step) & wmask_r);
  end

  assign beat      = HAS_READ && (st_r != ARX_IDLE) && f_ready;
  assign last_beat = (left_r == 8'h00);
  // lite never says exclusive okay; lock is ignored so plain okay always
  assign rresp_v   = `ARX_RESP_OKAY;
  assign f_in      = {id_r, mem[addr_r[WW +: 4]], rresp_v, last_beat};

  // burst engine: wrap bursts use hold state so the address folds; cache, prot, qos, region ignored
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      st_r    <= ARX_IDLE;
      addr_r  <= '0;
      left_r  <= 8'h00;
      wmask_r <= '0;
      size_r  <= 3'h0;
      id_r    <= '0;
    end
    else
    begin
      case (st_r)
        ARX_IDLE:
          if (HAS_READ && bus.arvalid && arready_r)
          begin
            addr_r  <= bus.araddr[NAW-1:0];
            size_r  <= bus.arsize;
            left_r  <= LITE ? 8'h00 : bus.arlen;
            id_r    <= LITE ? '0 : bus.arid;
            wmask_r <= ((NAW'(bus.arlen) + NAW'(1)) << bus.arsize) - NAW'(1);
            st_r    <= (!LITE && bus.arburst == `ARX_BURST_WRAP) ? ARX_HOLD : ARX_BURST;
          end
        ARX_BURST,
        ARX_HOLD:
          if (beat)
          begin
            addr_r <= addr_nxt;
            left_r <= left_r - 8'h01;
            if (last_beat)
              st_r <= ARX_IDLE;
          end
        default:
          st_r <= ARX_IDLE;
      endcase
    end

  arx_fifo #(
    .W (FW),
    .D (`ARX_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .in_data_in    (f_in),
    .in_valid_in   (beat),
    .in_ready_out  (f_ready),
    .out_data_out  (f_out),
    .out_valid_out (f_valid),
    .out_ready_in  (!rvalid_r || bus.rready)
  );

  // address ready from the next engine state, so the port comes straight from a flop
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      arready_r <= 1'b0;
    else if (st_r == ARX_IDLE)
      arready_r <= HAS_READ && !(bus.arvalid && arready_r);
    else
      arready_r <= HAS_READ && beat && last_beat;

  // read data output register; clears immediately under reset
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      rvalid_r <= 1'b0;
      rhold_r  <= '0;
    end
    else if (!rvalid_r || bus.rready)
    begin
      rvalid_r <= HAS_READ && f_valid;
      rhold_r  <= f_out;
    end

  // write response: one pending at a time; a done while bvalid_r is set is dropped, not held
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      bvalid_r <= 1'b0;
      bid_r    <= '0;
      bresp_r  <= `ARX_RESP_OKAY;
    end
    else if (bvalid_r && bus.bready)
      bvalid_r <= 1'b0;
    else if (HAS_WRITE && wr_done_in && !bvalid_r)
    begin
      bvalid_r <= 1'b1;
      bid_r    <= LITE ? '0 : wr_id_in;
      bresp_r  <= (LITE && wr_resp_in == `ARX_RESP_EXOKAY) ? `ARX_RESP_OKAY : wr_resp_in;
    end

  // busy flags registered so the user side sees clean levels
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      rd_busy_out <= 1'b0;
      wr_busy_out <= 1'b0;
    end
    else
    begin
      rd_busy_out <= (st_r != ARX_IDLE) || f_valid || rvalid_r;
      wr_busy_out <= bvalid_r && !bus.bready;
    end

  // channel outputs; user bits stay zero
  assign bus.arready = arready_r;
  assign bus.rvalid  = rvalid_r;
  assign bus.rid     = rhold_r[FW-1 -: IW];
  assign bus.rdata   = rhold_r[DW+2:3];
  assign bus.rresp   = rhold_r[2:1];
  assign bus.rlast   = LITE ? 1'b1 : rhold_r[0];
  assign bus.ruser   = '0;
  assign bus.bvalid  = bvalid_r;
  assign bus.bid     = bid_r;
  assign bus.bresp   = bresp_r;
  assign bus.buser   = '0;
endmodule

// *** axi_endpoint_read_and_response_test.sv ***
/*
  testbench joining master and slave; drives both user sides and checks data.
  assumes the default full build with a 16-word index memory on the slave.
*/
`timescale 1ns/1ps
`include "arx_defs.svh"
module axi_endpoint_read_and_response_test;
  import arx_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in = 1'b1;
  logic        req_in = 1'b0;
  logic [31:0] req_addr_in = 32'h0;
  logic [7:0]  req_len_in = 8'h0;
  logic [1:0]  req_burst_in = 2'h1;
  logic [3:0]  req_id_in = 4'h0;
  logic        wr_done_in = 1'b0;
  logic [3:0]  wr_id_in = 4'h0;
  logic [1:0]  wr_resp_in = 2'h0;
  logic        req_busy_out, beat_valid_out, beat_last_out, bresp_valid_out;
  logic [31:0] beat_data_out;
  logic [1:0]  beat_resp_out, bresp_out;
  logic        rd_busy_out, wr_busy_out;
  logic        lt_beat_valid, lt_beat_last, lt_bresp_valid;
  logic [31:0] lt_beat_data;
  logic [1:0]  lt_beat_resp, lt_bresp;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  arx_if bus_if ();
  arx_master u_arx_master (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus(bus_if), .req_in(req_in),
    .req_addr_in(req_addr_in), .req_len_in(req_len_in), .req_burst_in(req_burst_in), .req_id_in(req_id_in),
    .req_busy_out(req_busy_out), .beat_valid_out(beat_valid_out), .beat_data_out(beat_data_out),
    .beat_resp_out(beat_resp_out), .beat_last_out(beat_last_out), .bresp_valid_out(bresp_valid_out),
    .bresp_out(bresp_out));
  arx_slave u_arx_slave (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus(bus_if), .wr_done_in(wr_done_in),
    .wr_id_in(wr_id_in), .wr_resp_in(wr_resp_in), .wr_busy_out(wr_busy_out), .rd_busy_out(rd_busy_out));
  // lite pair serves the same requests in parallel
  arx_if lt_if ();
  arx_master u_arx_master_lite (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus(lt_if), .req_in(req_in),
    .req_addr_in(req_addr_in), .req_len_in(req_len_in), .req_burst_in(req_burst_in), .req_id_in(req_id_in),
    .req_busy_out(), .beat_valid_out(lt_beat_valid), .beat_data_out(lt_beat_data),
    .beat_resp_out(lt_beat_resp), .beat_last_out(lt_beat_last), .bresp_valid_out(lt_bresp_valid),
    .bresp_out(lt_bresp));
  arx_slave #(.LITE(1'b1)) u_arx_slave_lite (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus(lt_if),
    .wr_done_in(wr_done_in), .wr_id_in(wr_id_in), .wr_resp_in(wr_resp_in), .wr_busy_out(), .rd_busy_out());
  arx_link_chk u_arx_link_chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .arid(bus_if.arid),
    .araddr(bus_if.araddr), .arlen(bus_if.arlen), .arsize(bus_if.arsize), .arcache(bus_if.arcache),
    .arprot(bus_if.arprot), .arvalid(bus_if.arvalid), .arready(bus_if.arready), .rid(bus_if.rid),
    .rdata(bus_if.rdata), .rresp(bus_if.rresp), .rlast(bus_if.rlast), .ruser(bus_if.ruser),
    .rvalid(bus_if.rvalid), .rready(bus_if.rready), .buser(bus_if.buser), .bvalid(bus_if.bvalid));
  // 10 MHz clock
  always #50 ref_clk_in = ~ref_clk_in;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, far above the 120 or so cycles the tests need
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic step;
    @(posedge ref_clk_in);
    #1;
  endtask
  // word index of beat i; wrap stays inside the len+1 word window
  function automatic logic [31:0] exp_word(logic [31:0] a, logic [7:0] len, logic [1:0] bt, int i);
    logic [3:0] s;
    s = a[5:2];
    if (bt == `ARX_BURST_WRAP)
      return 32'((s & ~len[3:0]) | ((s + 4'(i)) & len[3:0]));
    return 32'(4'(s + 4'(i)));
  endfunction
  task automatic issue(input logic [31:0] a, input logic [7:0] len, input logic [1:0] bt, input logic [3:0] id);
    for (int k = 0; k < 50 && req_busy_out !== 1'b0; k++)
      step();
    req_addr_in = a;
    req_len_in = len;
    req_burst_in = bt;
    req_id_in = id;
    req_in = 1'b1;
    step();
    req_in = 1'b0;
    chk(32'(req_busy_out), 32'h1);
  endtask
  // one read burst, judged beat by beat at the master's user side
  task automatic do_read(input logic [31:0] a, input logic [7:0] len, input logic [1:0] bt, input logic [3:0] id);
    int n;
    int m;
    n = 0;
    m = 0;
    issue(a, len, bt, id);
    for (int k = 0; k < 300 && n <= int'(len); k++)
    begin
      step();
      if (bus_if.rvalid === 1'b1)
        chk(32'(bus_if.rid), 32'(id));
      if (beat_valid_out === 1'b1)
      begin
        chk(beat_data_out, exp_word(a, len, bt, n));
        chk(32'(beat_resp_out), 32'(`ARX_RESP_OKAY));
        chk(32'(beat_last_out), 32'(n == int'(len)));
        chk(32'(rd_busy_out), 32'h1);
        n++;
      end
      if (lt_beat_valid === 1'b1)
      begin
        chk(lt_beat_data, exp_word(a, len, bt, 0));
        chk(32'({lt_beat_resp, lt_beat_last}), 32'h1);
        m++;
      end
    end
    chk(32'(n), 32'(len) + 32'h1);
    chk(32'(m), 32'h1);
    step();
    chk(32'(rd_busy_out), 32'h0);
  endtask
  task automatic s_reads;
    do_read(32'h0000_0038, 8'h03, `ARX_BURST_INCR, 4'h3);
    do_read(32'h0000_0008, 8'h03, `ARX_BURST_WRAP, 4'h5);
    do_read(32'h0000_0010, 8'h01, `ARX_BURST_FIXED, 4'h9);
    do_read(32'hFFFF_F014, 8'h00, `ARX_BURST_INCR, 4'hF);
    do_read(32'h0000_0000, 8'h0F, `ARX_BURST_INCR, 4'h1);
  endtask
  // every response code, full build passes all four through
  task automatic s_bresp;
    logic seen;
    for (int c = 0; c < 4; c++)
    begin
      wr_done_in = 1'b1;
      wr_id_in = 4'(c + 6);
      wr_resp_in = 2'(c);
      step();
      wr_done_in = 1'b0;
      seen = 1'b0;
      for (int k = 0; k < 20 && !seen; k++)
      begin
        if (bus_if.bvalid === 1'b1)
          chk(32'(bus_if.bid), 32'(c + 6));
        if (bresp_valid_out === 1'b1)
        begin
          chk(32'(bresp_out), 32'(c));
          chk(32'({lt_bresp_valid, lt_bresp}), 32'({1'b1, (c == 1) ? 2'h0 : 2'(c)}));
          chk(32'(wr_busy_out), 32'h0);
          seen = 1'b1;
        end
        step();
      end
      chk(32'(seen), 32'h1);
    end
  endtask
  // reset in mid-burst, then the link must serve a fresh read
  task automatic s_reset;
    issue(32'h0, 8'h0F, `ARX_BURST_INCR, 4'h2);
    for (int k = 0; k < 20 && beat_valid_out !== 1'b1; k++)
      step();
    rst_n_in = 1'b0;
    #1;
    chk(32'({bus_if.rvalid, bus_if.arvalid, bus_if.bvalid}), 32'h0);
    repeat (20) step();
    rst_n_in = 1'b1;
    step();
    do_read(32'h0000_0024, 8'h01, `ARX_BURST_INCR, 4'h4);
  endtask
  initial
  begin
    // a real falling edge, so the asynchronous resets fire before the first clock
    #1;
    rst_n_in = 1'b0;
    repeat (20) step();
    rst_n_in = 1'b1;
    step();
    s_reads();
    s_bresp();
    s_reset();
    report_and_stop();
  end
endmodule
